/* core/ssg_pkg.sv */
// Purpose: Shared constants for the servo filter and gain switching block.
// Assumes: 25 MHz reference clock, 32-bit register port with byte offsets.
// Notes: Inertia ratios are held in tenths (40 means 4.0 times).
`default_nettype none
package ssg_pkg;
    // Clock and time base.
    localparam int unsigned CLK_FREQ_HZ = 32'h017D_7840;
    localparam int unsigned MS_PER_S = 32'h0000_03E8;

    // Register byte offsets, writable settings.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_NOTCH = 8'h04;
    localparam logic [7:0] OFS_INERTIA = 8'h08;
    localparam logic [7:0] OFS_POS_GAIN_B = 8'h0C;
    localparam logic [7:0] OFS_SPD_GAIN_B = 8'h10;
    localparam logic [7:0] OFS_INT_TIME = 8'h14;
    localparam logic [7:0] OFS_ALT_INERTIA = 8'h18;
    localparam logic [7:0] OFS_POS_PCT = 8'h1C;
    localparam logic [7:0] OFS_SPD_PCT = 8'h20;
    localparam logic [7:0] OFS_INT_PCT = 8'h24;
    localparam logic [7:0] OFS_COND_SEL = 8'h28;
    localparam logic [7:0] OFS_THRESHOLD = 8'h2C;
    localparam logic [7:0] OFS_TIME_CONST = 8'h30;
    localparam logic [7:0] OFS_MODEL_POS = 8'h34;
    localparam logic [7:0] OFS_MODEL_SPD = 8'h38;
    // Register byte offsets, read-only state.
    localparam logic [7:0] OFS_STATUS = 8'h40;
    localparam logic [7:0] OFS_EFF_POS = 8'h44;
    localparam logic [7:0] OFS_EFF_SPD = 8'h48;
    localparam logic [7:0] OFS_EFF_INT = 8'h4C;
    localparam logic [7:0] OFS_EFF_INERTIA = 8'h50;
    localparam logic [7:0] OFS_LPF_CORNER = 8'h54;

    // Control and notch register fields.
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_LPF_OFF_BIT = 4;
    localparam int unsigned CTRL_CMD_BIT = 8;
    localparam int unsigned NOTCH_DEPTH_LSB = 8;

    // Gain adjustment mode and trigger selection codes.
    localparam logic [3:0] MODE_MANUAL2 = 4'h2;
    localparam logic [3:0] COND_COMMAND = 4'h1;
    localparam logic [3:0] COND_CMD_FREQ = 4'h2;
    localparam logic [3:0] COND_DROOP = 4'h3;
    localparam logic [3:0] COND_SPEED = 4'h4;

    // Notch depth attenuation in dB per depth code.
    localparam logic [7:0] DEPTH_DB_0 = 8'h28;
    localparam logic [7:0] DEPTH_DB_1 = 8'h0E;
    localparam logic [7:0] DEPTH_DB_2 = 8'h08;
    localparam logic [7:0] DEPTH_DB_3 = 8'h04;

    // Arithmetic constants.
    localparam logic [15:0] PCT_UNITY = 16'h0064;
    localparam logic [15:0] LPF_GAIN_MUL = 16'h000A;
    localparam logic [15:0] RATIO_SCALE = 16'h000A;
    localparam logic [15:0] INV_2PI_Q16 = 16'h28BE;
    localparam int unsigned INV_2PI_SHIFT = 16;
    localparam int unsigned LAG_FRAC = 8;

    // Reset values of the settings.
    localparam logic [15:0] RST_INERTIA = 16'h0046;
    localparam logic [15:0] RST_POS_GAIN_B = 16'h0019;
    localparam logic [15:0] RST_SPD_GAIN_B = 16'h0325;
    localparam logic [15:0] RST_INT_TIME = 16'h0030;
    localparam logic [15:0] RST_TIME_CONST = 16'h0001;
    localparam logic [15:0] RST_MODEL_POS = 16'h0023;
    localparam logic [15:0] RST_MODEL_SPD = 16'h00B1;
    localparam logic [15:0] RST_THRESHOLD = 16'h000A;
endpackage
`default_nettype wire

/* core/ssg_gain_switch.sv */
// Purpose: Notch and low-pass filter settings plus smoothed gain switching.
// Assumes: Monitored quantities come from logic on ref_clk, no sync needed.
// Notes: The lag steps once per millisecond toward its target value.
//
// Notes on behaviour
// [R01] Notch depth codes map to 40/14/8/4 dB.
// [R02] Notch acts only at its selected frequency.
// [R03] Low-pass filter on after reset, may be disabled.
// [R04] Corner equals ten VG2 over 2pi(1+ratio).
// [R05] Switching only in manual mode 2.
// [R06] Model gains never altered by switching.
// [R07] Switched state uses the alternate inertia ratio.
// [R08] Switched gains scale by own percentage over 100.
// [R09] Hundred percent leaves the value unchanged.
// [R10] Trigger taken from lowest selection digit.
// [R11] Digit 4 switches when speed reaches threshold.
// [R12] Threshold units follow the selected quantity.
// [R13] Switched values follow first-order lag in ms.
// [R14] Switch while moving or stopped, or by command.
// [R15] Selection 0003 compares droop pulses to threshold.
// [R16] Condition false returns values through same lag.
// [R17] Frequency and droop switch at threshold or above.
`default_nettype none

module ssg_lag
    import ssg_pkg::*;
#(
    parameter int unsigned WIDTH = 16
)(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ms_tick,
    input wire logic [WIDTH-1:0] target,
    input wire logic [15:0] time_const_ms,
    output logic [WIDTH-1:0] value
);
    logic [WIDTH+LAG_FRAC-1:0] acc_reg;
    logic signed [WIDTH+LAG_FRAC+1:0] diff;
    logic signed [WIDTH+LAG_FRAC+1:0] step;

    // Step is the remaining distance over the time constant, at least one lsb.
    always_comb
    begin
        diff = $signed({2'b00, target, {LAG_FRAC{1'b0}}})
             - $signed({2'b00, acc_reg});
        step = diff / $signed({2'b00, {(WIDTH+LAG_FRAC-16){1'b0}},
                                time_const_ms});
        if (step == '0 && diff > 0)
            step = (WIDTH+LAG_FRAC+2)'(1);
        else if (step == '0 && diff < 0)
            step = (WIDTH+LAG_FRAC+2)'(-1);
    end

    // A zero time constant jumps straight to the target.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            acc_reg <= '0;
        else if (ms_tick && time_const_ms == 16'h0000)
            acc_reg <= {target, {LAG_FRAC{1'b0}}}; // R13
        else if (ms_tick)
            acc_reg <= acc_reg + step[WIDTH+LAG_FRAC-1:0]; // R13
    end

    assign value = acc_reg[WIDTH+LAG_FRAC-1:LAG_FRAC];
endmodule

module ssg_gain_switch
    import ssg_pkg::*;
#(
    parameter int unsigned MS_CYCLES = CLK_FREQ_HZ / MS_PER_S
)(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic signed [31:0] cmd_freq_kpps,
    input wire logic signed [31:0] droop_pulses,
    input wire logic signed [31:0] motor_speed_rpm,
    output logic [15:0] model_position_gain,
    output logic [15:0] model_speed_gain,
    output logic [15:0] eff_position_gain,
    output logic [15:0] eff_speed_gain,
    output logic [15:0] eff_integral_time,
    output logic [15:0] eff_inertia_ratio,
    output logic lpf_enable,
    output logic [15:0] lpf_corner_hz,
    output logic [7:0] notch_freq_sel,
    output logic [7:0] notch_atten_db,
    output logic gain_switched
);
    logic [3:0] gain_mode_reg;
    logic lpf_off_reg;
    logic switch_cmd_reg;
    logic [7:0] notch_freq_reg;
    logic [1:0] notch_depth_reg;
    logic [15:0] load_inertia_ratio;
    logic [15:0] position_loop_gain_b;
    logic [15:0] speed_loop_gain_b;
    logic [15:0] speed_integral_time;
    logic [15:0] alt_load_inertia_ratio;
    logic [15:0] position_gain_change_pct;
    logic [15:0] speed_gain_change_pct;
    logic [15:0] integral_time_change_pct;
    logic [15:0] switch_condition_select;
    logic [15:0] switch_threshold;
    logic [15:0] switch_time_constant;
    logic [15:0] model_pos_reg;
    logic [15:0] model_spd_reg;
    logic switched_reg;
    logic switched_next;
    logic [31:0] tick_cnt_reg;
    logic ms_tick;
    logic [15:0] pos_target;
    logic [15:0] spd_target;
    logic [15:0] int_target;
    logic [15:0] inertia_target;
    logic [15:0] corner_reg;
    logic [7:0] atten_reg;
    logic [31:0] rdata_reg;
    logic [3:0] cond_digit;
    logic [31:0] thr_ext;

    // Scales a setting by a percentage; saturates rather than wrapping.
    function automatic logic [15:0] scale_pct(input logic [15:0] base,
                                              input logic [15:0] pct);
        logic [31:0] prod;
        prod = (base * pct) / {16'h0000, PCT_UNITY};
        scale_pct = (prod[31:16] != 16'h0000) ? 16'hFFFF : prod[15:0];
    endfunction

    // Magnitude of a signed monitor input, so reverse motion also switches.
    function automatic logic [31:0] mag(input logic signed [31:0] v);
        mag = v[31] ? 32'(-v) : 32'(v);
    endfunction

    // Register writes from software or the servo controller.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            gain_mode_reg <= MODE_MANUAL2;
            lpf_off_reg <= 1'b0; // R03
            switch_cmd_reg <= 1'b0;
            notch_freq_reg <= 8'h00;
            notch_depth_reg <= 2'b00;
            load_inertia_ratio <= RST_INERTIA;
            position_loop_gain_b <= RST_POS_GAIN_B;
            speed_loop_gain_b <= RST_SPD_GAIN_B;
            speed_integral_time <= RST_INT_TIME;
            alt_load_inertia_ratio <= RST_INERTIA;
            position_gain_change_pct <= PCT_UNITY;
            speed_gain_change_pct <= PCT_UNITY;
            integral_time_change_pct <= PCT_UNITY;
            switch_condition_select <= 16'h0000;
            switch_threshold <= RST_THRESHOLD;
            switch_time_constant <= RST_TIME_CONST;
            model_pos_reg <= RST_MODEL_POS;
            model_spd_reg <= RST_MODEL_SPD;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                OFS_CTRL:
                begin
                    gain_mode_reg <= reg_wdata[CTRL_MODE_LSB +: 4];
                    lpf_off_reg <= reg_wdata[CTRL_LPF_OFF_BIT]; // R03
                    switch_cmd_reg <= reg_wdata[CTRL_CMD_BIT]; // R14
                end
                OFS_NOTCH:
                begin
                    notch_freq_reg <= reg_wdata[7:0];
                    notch_depth_reg <= reg_wdata[NOTCH_DEPTH_LSB +: 2];
                end
                OFS_INERTIA: load_inertia_ratio <= reg_wdata[15:0];
                OFS_POS_GAIN_B: position_loop_gain_b <= reg_wdata[15:0];
                OFS_SPD_GAIN_B: speed_loop_gain_b <= reg_wdata[15:0];
                OFS_INT_TIME: speed_integral_time <= reg_wdata[15:0];
                OFS_ALT_INERTIA: alt_load_inertia_ratio <= reg_wdata[15:0];
                OFS_POS_PCT: position_gain_change_pct <= reg_wdata[15:0];
                OFS_SPD_PCT: speed_gain_change_pct <= reg_wdata[15:0];
                OFS_INT_PCT: integral_time_change_pct <= reg_wdata[15:0];
                OFS_COND_SEL: switch_condition_select <= reg_wdata[15:0];
                OFS_THRESHOLD: switch_threshold <= reg_wdata[15:0];
                OFS_TIME_CONST: switch_time_constant <= reg_wdata[15:0];
                OFS_MODEL_POS: model_pos_reg <= reg_wdata[15:0];
                OFS_MODEL_SPD: model_spd_reg <= reg_wdata[15:0];
                default: ;
            endcase
        end
    end

    // Trigger decode; the threshold unit is whatever the chosen input uses.
    always_comb
    begin
        cond_digit = switch_condition_select[3:0]; // R10
        thr_ext = {16'h0000, switch_threshold}; // R12
        switched_next = 1'b0;
        case (cond_digit)
            COND_COMMAND: switched_next = switch_cmd_reg; // R14
            COND_CMD_FREQ:
                switched_next = mag(cmd_freq_kpps) >= thr_ext; // R17
            COND_DROOP: switched_next = mag(droop_pulses) >= thr_ext; // R15
            COND_SPEED: switched_next = mag(motor_speed_rpm) >= thr_ext; // R11
            default: switched_next = 1'b0;
        endcase
        // Auto tuning owns the gains, so switching is held off there.
        if (gain_mode_reg != MODE_MANUAL2)
            switched_next = 1'b0; // R05
    end

    // Switched state; works at rest or in motion alike.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            switched_reg <= 1'b0;
        else
            switched_reg <= switched_next; // R16
    end

    // Targets; a false condition falls back to the normal settings.
    always_comb
    begin
        pos_target = position_loop_gain_b;
        spd_target = speed_loop_gain_b;
        int_target = speed_integral_time;
        inertia_target = load_inertia_ratio;
        if (switched_reg)
        begin
            pos_target = scale_pct(position_loop_gain_b,
                                   position_gain_change_pct); // R08 R09
            spd_target = scale_pct(speed_loop_gain_b,
                                   speed_gain_change_pct); // R08
            int_target = scale_pct(speed_integral_time,
                                   integral_time_change_pct); // R08
            inertia_target = alt_load_inertia_ratio; // R07
        end
    end

    // Millisecond tick for the smoothing lag.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            tick_cnt_reg <= 32'h0000_0000;
        else if (ms_tick)
            tick_cnt_reg <= 32'h0000_0000;
        else
            tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end
    assign ms_tick = (tick_cnt_reg == 32'(MS_CYCLES - 1));

    // One lag per switched quantity, all with the same time constant.
    ssg_lag #(.WIDTH(16)) u_lag_pos (.ref_clk(ref_clk), .rst_n(rst_n),
        .ms_tick(ms_tick), .target(pos_target),
        .time_const_ms(switch_time_constant), .value(eff_position_gain));
    ssg_lag #(.WIDTH(16)) u_lag_spd (.ref_clk(ref_clk), .rst_n(rst_n),
        .ms_tick(ms_tick), .target(spd_target),
        .time_const_ms(switch_time_constant), .value(eff_speed_gain));
    ssg_lag #(.WIDTH(16)) u_lag_int (.ref_clk(ref_clk), .rst_n(rst_n),
        .ms_tick(ms_tick), .target(int_target),
        .time_const_ms(switch_time_constant), .value(eff_integral_time));
    ssg_lag #(.WIDTH(16)) u_lag_ine (.ref_clk(ref_clk), .rst_n(rst_n),
        .ms_tick(ms_tick), .target(inertia_target),
        .time_const_ms(switch_time_constant), .value(eff_inertia_ratio));

    // Corner follows the live gain and ratio, so it tracks the switch too.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            corner_reg <= 16'h0000;
        else
            corner_reg <= 16'((((48'(eff_speed_gain) * LPF_GAIN_MUL
                * RATIO_SCALE * INV_2PI_Q16) >> INV_2PI_SHIFT))
                / (48'(RATIO_SCALE) + 48'(eff_inertia_ratio))); // R04
    end

    // Depth code to attenuation; the notch only cuts around its centre.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            atten_reg <= DEPTH_DB_0;
        else
        begin
            case (notch_depth_reg)
                2'b00: atten_reg <= DEPTH_DB_0; // R01
                2'b01: atten_reg <= DEPTH_DB_1; // R01
                2'b10: atten_reg <= DEPTH_DB_2; // R01
                default: atten_reg <= DEPTH_DB_3; // R01
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || !reg_rd)
            rdata_reg <= 32'h0000_0000;
        else
        begin
            case (reg_addr)
                OFS_CTRL: rdata_reg <= {23'h00_0000, switch_cmd_reg, 3'h0,
                                        lpf_off_reg, gain_mode_reg};
                OFS_NOTCH: rdata_reg <= {22'h00_0000, notch_depth_reg,
                                         notch_freq_reg};
                OFS_INERTIA: rdata_reg <= 32'(load_inertia_ratio);
                OFS_POS_GAIN_B: rdata_reg <= 32'(position_loop_gain_b);
                OFS_SPD_GAIN_B: rdata_reg <= 32'(speed_loop_gain_b);
                OFS_INT_TIME: rdata_reg <= 32'(speed_integral_time);
                OFS_ALT_INERTIA: rdata_reg <= 32'(alt_load_inertia_ratio);
                OFS_POS_PCT: rdata_reg <= 32'(position_gain_change_pct);
                OFS_SPD_PCT: rdata_reg <= 32'(speed_gain_change_pct);
                OFS_INT_PCT: rdata_reg <= 32'(integral_time_change_pct);
                OFS_COND_SEL: rdata_reg <= 32'(switch_condition_select);
                OFS_THRESHOLD: rdata_reg <= 32'(switch_threshold);
                OFS_TIME_CONST: rdata_reg <= 32'(switch_time_constant);
                OFS_MODEL_POS: rdata_reg <= 32'(model_pos_reg);
                OFS_MODEL_SPD: rdata_reg <= 32'(model_spd_reg);
                OFS_STATUS: rdata_reg <= {22'h00_0000, atten_reg,
                                          !lpf_off_reg, switched_reg};
                OFS_EFF_POS: rdata_reg <= 32'(eff_position_gain);
                OFS_EFF_SPD: rdata_reg <= 32'(eff_speed_gain);
                OFS_EFF_INT: rdata_reg <= 32'(eff_integral_time);
                OFS_EFF_INERTIA: rdata_reg <= 32'(eff_inertia_ratio);
                OFS_LPF_CORNER: rdata_reg <= 32'(corner_reg);
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // Model gains pass straight from their settings, never switched.
    assign model_position_gain = model_pos_reg; // R06
    assign model_speed_gain = model_spd_reg; // R06
    assign lpf_enable = !lpf_off_reg;
    assign lpf_corner_hz = corner_reg;
    assign notch_freq_sel = notch_freq_reg; // R02
    assign notch_atten_db = atten_reg;
    assign gain_switched = switched_reg;
    assign reg_rdata = rdata_reg;

    // Checks of the switching and filter behaviour.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_mode_gate_off: assert property ((gain_mode_reg != MODE_MANUAL2)
        |=> !switched_reg) else $error("switch outside manual mode 2"); // R05
    a_speed_trig_on: assert property ((gain_mode_reg == MODE_MANUAL2 &&
        cond_digit == COND_SPEED && mag(motor_speed_rpm) >= thr_ext)
        |=> switched_reg) else $error("speed trigger missed"); // R11
    a_droop_trig_on: assert property ((gain_mode_reg == MODE_MANUAL2 &&
        cond_digit == COND_DROOP && mag(droop_pulses) >= thr_ext)
        |=> switched_reg) else $error("droop trigger missed"); // R15
    a_freq_trig_off: assert property ((cond_digit == COND_CMD_FREQ &&
        mag(cmd_freq_kpps) < thr_ext) |=> !switched_reg)
        else $error("frequency below threshold switched"); // R17
    a_cmd_trig_follow: assert property ((gain_mode_reg == MODE_MANUAL2 &&
        cond_digit == COND_COMMAND) |=> switched_reg == $past(switch_cmd_reg))
        else $error("command switch not followed"); // R14
    a_model_gain_hold: assert property ((switched_reg != $past(switched_reg)
        && !$past(reg_wr)) |-> $stable(model_position_gain) &&
        $stable(model_speed_gain)) else $error("model gain moved"); // R06
    a_unity_pct_same: assert property ((switched_reg &&
        position_gain_change_pct == PCT_UNITY) |-> pos_target ==
        position_loop_gain_b) else $error("unity ratio changed gain"); // R09
    a_alt_inertia_used: assert property (switched_reg |->
        inertia_target == alt_load_inertia_ratio)
        else $error("alternate inertia not used"); // R07
    a_lpf_reset_on: assert property ($rose(rst_n) |-> lpf_enable)
        else $error("low-pass not on after reset"); // R03
    a_depth_deep_db: assert property ((notch_depth_reg == 2'b00) |=>
        notch_atten_db == DEPTH_DB_0) else $error("deep notch wrong"); // R01

    c_speed_switch: cover property ($rose(switched_reg) &&
        cond_digit == COND_SPEED);
    c_cmd_switch: cover property ($rose(switched_reg) &&
        cond_digit == COND_COMMAND);
    c_switch_back: cover property ($fell(switched_reg));
    c_lpf_disabled: cover property (!lpf_enable);
endmodule
`default_nettype wire

/* verif/ssg_ctrl_model.sv */
// Purpose: Far-side controller model that moves the monitored quantities.
// Assumes: The bench names the moving quantity and its value.
// Notes: Idle quantities wander below 16, well under any bench threshold.
`default_nettype none
module ssg_ctrl_model (
    input wire logic ref_clk,
    input wire logic [3:0] mon_sel,
    input wire logic signed [31:0] mon_val,
    output logic signed [31:0] cmd_freq_kpps,
    output logic signed [31:0] droop_pulses,
    output logic signed [31:0] motor_speed_rpm
);
    timeunit 1ns;
    timeprecision 1ns;

    // Quiet start so no quantity is unknown at time zero.
    initial
    begin
        cmd_freq_kpps = 32'sh0000_0000;
        droop_pulses = 32'sh0000_0000;
        motor_speed_rpm = 32'sh0000_0000;
    end

    // Idle quantities keep changing so a stale value never looks valid.
    always @(posedge ref_clk)
    begin
        cmd_freq_kpps <= (mon_sel == 4'h2) ? mon_val
            : 32'($urandom_range(15));
        droop_pulses <= (mon_sel == 4'h3) ? mon_val
            : 32'($urandom_range(15));
        motor_speed_rpm <= (mon_sel == 4'h4) ? mon_val
            : 32'($urandom_range(15));
    end
endmodule
`default_nettype wire

/* verif/ssg_gain_switch_tb_top.sv */
// Purpose: Self-checking bench for filter settings and gain switching.
// Assumes: Short millisecond so the lag settles in a few hundred cycles.
// Notes: Settings are random per trigger kind, with fixed corner cases.
`default_nettype none
module ssg_gain_switch_tb_top
    import ssg_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MSC = 8;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [3:0] mon_sel = 4'h0;
    logic signed [31:0] mon_val = 32'sh0000_0000;
    logic signed [31:0] cf, dp, sp;
    logic [15:0] mpg, msg, epg, esg, eit, eir, lpc;
    logic lpe, gsw;
    logic [7:0] nfs, nad;
    logic [15:0] s [11];
    logic [7:0] dbt [4] = '{DEPTH_DB_0, DEPTH_DB_1, DEPTH_DB_2, DEPTH_DB_3};
    logic [7:0] ofs_tab [11] = '{OFS_INERTIA, OFS_POS_GAIN_B, OFS_SPD_GAIN_B,
        OFS_INT_TIME, OFS_ALT_INERTIA, OFS_POS_PCT, OFS_SPD_PCT, OFS_INT_PCT,
        OFS_THRESHOLD, OFS_MODEL_POS, OFS_MODEL_SPD};
    int lo_tab [11] = '{0, 10, 50, 5, 0, 50, 50, 50, 100, 1, 1};
    int hi_tab [11] = '{200, 500, 2000, 200, 200, 250, 250, 250, 1000,
        999, 999};
    int err_count = 0;
    int check_count = 0;

    ssg_gain_switch #(.MS_CYCLES(MSC)) i_ssg_gain_switch (.ref_clk(ref_clk),
        .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cmd_freq_kpps(cf), .droop_pulses(dp), .motor_speed_rpm(sp),
        .model_position_gain(mpg), .model_speed_gain(msg),
        .eff_position_gain(epg), .eff_speed_gain(esg),
        .eff_integral_time(eit), .eff_inertia_ratio(eir),
        .lpf_enable(lpe), .lpf_corner_hz(lpc), .notch_freq_sel(nfs),
        .notch_atten_db(nad), .gain_switched(gsw));
    ssg_ctrl_model i_ssg_ctrl_model (.ref_clk(ref_clk), .mon_sel(mon_sel),
        .mon_val(mon_val), .cmd_freq_kpps(cf), .droop_pulses(dp),
        .motor_speed_rpm(sp));

    // Free-running 25 MHz clock.
    always #20 ref_clk = ~ref_clk;

    task automatic give_verdict();
        if (err_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Register port master; a one-cycle strobe with settled address and data.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data exist only in the cycle after the strobe, so sample there.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    function automatic logic [15:0] scl(input logic [15:0] v,
                                        input logic [15:0] p);
        logic [31:0] t;
        t = v * p / PCT_UNITY;
        return (t > 32'h0000_FFFF) ? 16'hFFFF : t[15:0];
    endfunction

    function automatic int cor();
        return int'($floor(s[2] * 100.0 / (6.2831853 * (10 + s[0]))));
    endfunction

    // Sets or clears the command bit for trigger 1, else puts the input just below the threshold, or at it with either sign.
    task automatic trig(input logic [3:0] c, input logic on);
        if (c == 4'h1)
            wr(OFS_CTRL, on ? 32'h0000_0102 : 32'h0000_0002);
        else
        begin
            @(posedge ref_clk);
            mon_sel <= c;
            mon_val <= (on && $urandom_range(1)) ? -32'(s[8])
                       : 32'(s[8]) - 32'(!on);
        end
    endtask

    task automatic chk_eff(input logic sw);
        chk(gsw, sw);
        chk(epg, sw ? scl(s[1], s[5]) : s[1]);
        chk(esg, sw ? scl(s[2], s[6]) : s[2]);
        chk(eit, sw ? scl(s[3], s[7]) : s[3]);
        chk(eir, sw ? s[4] : s[0]);
        chk(mpg, s[9]);
        chk(msg, s[10]);
    endtask

    // Hang guard, well beyond the expected length of the run.
    initial
    begin
        repeat (30000) @(posedge ref_clk);
        err_count++;
        give_verdict();
    end

    initial
    begin
        logic [31:0] d;
        logic [7:0] v;
        d = $urandom(55852);
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(OFS_STATUS, d);
        chk(d, 32'h0000_00A2);
        for (int i = 0; i < 4; i++)
        begin
            v = 8'($urandom_range(255));
            wr(OFS_NOTCH, {22'h00_0000, 2'(i), v});
            settle(1);
            chk(nad, dbt[i]);
            chk(nfs, v);
        end
        wr(OFS_CTRL, 32'h0000_0012);
        settle(1);
        chk(lpe, 1'b0);
        wr(OFS_CTRL, 32'h0000_0002);
        wr(OFS_STATUS, 32'hFFFF_FFFF);
        rd(OFS_STATUS, d);
        chk(d, 32'h0000_0012);
        rd(8'hFC, d);
        chk(d, 32'h0000_0000);
        // Each trigger kind with fresh settings and an idle lag.
        for (int c = 1; c <= 4; c++)
        begin
            for (int i = 0; i < 11; i++)
            begin
                s[i] = 16'($urandom_range(hi_tab[i], lo_tab[i]));
                wr(ofs_tab[i], {16'h0000, s[i]});
            end
            wr(OFS_TIME_CONST, 32'h0000_0000);
            wr(OFS_COND_SEL, 32'h0000_0100 | 32'(c));
            trig(4'(c), 1'b0);
            settle(3 * MSC);
            chk_eff(1'b0);
            chk(32'(lpc >= cor() - 1 && lpc <= cor() + 1), 32'h1);
            trig(4'(c), 1'b1);
            settle(3 * MSC);
            chk_eff(1'b1);
            wr(OFS_CTRL, 32'h0000_0003);
            settle(2);
            chk(gsw, 1'b0);
            wr(OFS_CTRL, 32'h0000_0002);
            trig(4'(c), 1'b0);
            settle(3 * MSC);
            chk_eff(1'b0);
        end
        // Slow lag: the speed gain must pass through middle values.
        s[5] = PCT_UNITY;
        s[2] = 16'h03E8;
        s[6] = 16'h00C8;
        wr(OFS_POS_PCT, {16'h0000, s[5]});
        wr(OFS_SPD_GAIN_B, {16'h0000, s[2]});
        wr(OFS_SPD_PCT, {16'h0000, s[6]});
        settle(3 * MSC);
        wr(OFS_TIME_CONST, 32'h0000_0004);
        trig(4'h4, 1'b1);
        settle(2 * MSC + 2);
        chk(epg, s[1]);
        chk(32'(esg > s[2] && esg < 16'h07D0), 32'h1);
        settle(80 * MSC);
        chk_eff(1'b1);
        give_verdict();
    end
endmodule
`default_nettype wire
